// ==== logic/lcdc_top.sv ====
// Purpose: LCD duty, pin mode and low-power control with AXI4-Lite registers
// Assumes: wait_mode and deep_sleep_mode come from another domain
// Notes: Two writes and one read may be open at a time
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_regs.svh"
module lcdc_top
  import lcdc_pkg::*;
#(
  parameter int unsigned PANEL_DIV = `LCDC_PANEL_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wait_mode,
  input wire logic deep_sleep_mode,
  output logic [7:0] backplane_drive,
  output logic driver_run,
  output logic pump_run,
  output logic regulator_on,
  output logic gpio_complementary,
  output logic gpio_ref_rail3,
  output logic irq
);
  lcdc_st_t st_reg;
  lcdc_st_t st_next;
  logic [2:0] bp_index;
  logic frame_start;

  function automatic lcdc_reg_t decode(input logic [7:0] addr);
    case (addr)
      `LCDC_OFS_CTRL: decode = REG_CTRL;
      `LCDC_OFS_SETUP: decode = REG_SETUP;
      `LCDC_OFS_SUPPLY: decode = REG_SUPPLY;
      `LCDC_OFS_STAT: decode = REG_STAT;
      `LCDC_OFS_MASK: decode = REG_MASK;
      `LCDC_OFS_STATE: decode = REG_STATE;
      default: decode = REG_NONE;
    endcase
  endfunction : decode

  // Only byte lane 0 carries register bits
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] data,
    input logic strb0
  );
    merge = strb0 ? data : old;
  endfunction : merge

  lcdc_frame_gen #(
    .PANEL_DIV(PANEL_DIV)
  ) u_frame_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(st_reg.pins.driver_run),
    .duty_sel(st_reg.setup.duty_sel),
    .frame_prescaler(st_reg.setup.frame_prescaler),
    .bp_index(bp_index),
    .frame_start(frame_start)
  );

  always_comb begin
    lcdc_reg_t wsel;
    lcdc_reg_t rsel;
    logic do_write;
    logic irq_clr;
    logic halt;
    logic full_comp;
    wsel = decode(st_reg.aw_addr);
    rsel = decode(s_axi_araddr);
    do_write = 1'b0;
    irq_clr = 1'b0;
    halt = 1'b0;
    full_comp = 1'b0;
    st_next = st_reg;

    // Mode levels cross in through two flops
    st_next.wait_meta = wait_mode;
    st_next.wait_sync = st_reg.wait_meta;
    st_next.sleep_meta = deep_sleep_mode;
    st_next.sleep_sync = st_reg.sleep_meta;

    // Write address and data are taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_strb0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      do_write = 1'b1;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = (wsel == REG_NONE) ? `LCDC_RESP_SLVERR : `LCDC_RESP_OKAY;
    end
    if (do_write) begin
      case (wsel)
        REG_CTRL: begin
          st_next.ctrl = merge(st_reg.ctrl, st_reg.w_data, st_reg.w_strb0);
          st_next.ctrl.rsvd = '0;
        end
        REG_SETUP: begin
          st_next.setup = merge(st_reg.setup, st_reg.w_data, st_reg.w_strb0);
          st_next.setup.rsvd = '0;
        end
        REG_SUPPLY: begin
          st_next.supply = merge(st_reg.supply, st_reg.w_data, st_reg.w_strb0);
          st_next.supply.rsvd = '0;
        end
        REG_STAT: irq_clr = st_reg.w_strb0 && st_reg.w_data[0];
        REG_MASK: begin
          if (st_reg.w_strb0) begin
            st_next.irq_mask = st_reg.w_data[0];
          end
        end
        default: begin
        end
      endcase
    end
    st_next.awready = !st_next.aw_held;
    st_next.wready = !st_next.w_held;

    // Read path answers one cycle after the address is taken
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = (rsel == REG_NONE) ? `LCDC_RESP_SLVERR : `LCDC_RESP_OKAY;
      st_next.rdata = '0;
      case (rsel)
        REG_CTRL: st_next.rdata[7:0] = st_reg.ctrl;
        REG_SETUP: st_next.rdata[7:0] = st_reg.setup;
        REG_SUPPLY: st_next.rdata[7:0] = st_reg.supply;
        REG_STAT: st_next.rdata[0] = st_reg.irq_stat;
        REG_MASK: st_next.rdata[0] = st_reg.irq_mask;
        REG_STATE: st_next.rdata[7:0] = {bp_index, st_reg.pins.driver_run,
          st_reg.pins.pump_run, st_reg.pins.regulator_on,
          st_reg.pins.gpio_complementary, st_reg.pins.gpio_ref_rail3};
        default: begin
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // Sticky frame flag: a new frame wins over a same-cycle clear
    st_next.irq_stat = (st_reg.irq_stat && !irq_clr)
      || (frame_start && st_reg.ctrl.frame_irq_enable);
    st_next.irq = st_next.irq_stat && st_next.irq_mask;

    halt = (st_reg.ctrl.halt_in_wait && st_reg.wait_sync)
      || (st_reg.ctrl.halt_in_deep_sleep && st_reg.sleep_sync);
    st_next.pins.driver_run = !halt;
    st_next.pins.pump_run = !halt && st_reg.supply.charge_pump_enable;
    // Regulator needs the pump as its load
    st_next.pins.regulator_on = st_next.pins.pump_run
      && st_reg.supply.regulator_enable;

    full_comp = st_reg.ctrl.complementary_drive_enable
      && (st_reg.supply.supply_source_sel == `LCDC_SUPPLY_EXT)
      && !st_reg.supply.regulator_enable;
    st_next.pins.gpio_complementary = full_comp;
    st_next.pins.gpio_ref_rail3 = full_comp;

    // One-hot backplane select; all off while halted
    st_next.pins.backplane_drive = '0;
    if (st_reg.pins.driver_run && !halt) begin
      st_next.pins.backplane_drive[bp_index] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.setup <= `LCDC_SETUP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign backplane_drive = st_reg.pins.backplane_drive;
  assign driver_run = st_reg.pins.driver_run;
  assign pump_run = st_reg.pins.pump_run;
  assign regulator_on = st_reg.pins.regulator_on;
  assign gpio_complementary = st_reg.pins.gpio_complementary;
  assign gpio_ref_rail3 = st_reg.pins.gpio_ref_rail3;
  assign irq = st_reg.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wait_halt;
    st_reg.ctrl.halt_in_wait && st_reg.wait_sync;
  endsequence

  sequence s_sleep_halt;
    st_reg.ctrl.halt_in_deep_sleep && st_reg.sleep_sync;
  endsequence

  sequence s_frame_pulse;
    frame_start ##1 !frame_start;
  endsequence

  // Drive trails the duty field by two flops, so compare with the older value
  property p_bp_in_duty;
    (backplane_drive >> ({1'b0, $past(st_reg.setup.duty_sel, 2)} + 4'h1)) == 8'h00
      && $onehot0(backplane_drive);
  endproperty
  a_bp_in_duty: assert property (p_bp_in_duty)
    else $error("backplane beyond duty selection");

  property p_duty_reset;
    !$past(aresetn) |-> st_reg.setup.duty_sel == `LCDC_DUTY_RST;
  endproperty
  a_duty_reset: assert property (p_duty_reset)
    else $error("duty selection not 011 after reset");

  property p_frame_irq;
    frame_start && st_reg.ctrl.frame_irq_enable |=> st_reg.irq_stat;
  endproperty
  a_frame_irq: assert property (p_frame_irq)
    else $error("frame start did not set the flag");

  property p_no_frame_irq;
    !st_reg.irq_stat && !(frame_start && st_reg.ctrl.frame_irq_enable)
      |=> !st_reg.irq_stat;
  endproperty
  a_no_frame_irq: assert property (p_no_frame_irq)
    else $error("flag set without an enabled frame start");

  property p_full_comp;
    st_reg.ctrl.complementary_drive_enable && !st_reg.supply.regulator_enable
      && st_reg.supply.supply_source_sel == `LCDC_SUPPLY_EXT
      |=> gpio_complementary && gpio_ref_rail3;
  endproperty
  a_full_comp: assert property (p_full_comp)
    else $error("complementary drive not entered");

  property p_open_drain;
    !(st_reg.ctrl.complementary_drive_enable && !st_reg.supply.regulator_enable
      && st_reg.supply.supply_source_sel == `LCDC_SUPPLY_EXT)
      |=> !gpio_complementary && !gpio_ref_rail3;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain not kept");

  property p_wait_halt;
    s_wait_halt |=> !driver_run && !pump_run ##1 backplane_drive == 8'h00;
  endproperty
  a_wait_halt: assert property (p_wait_halt)
    else $error("driver running in wait");

  property p_sleep_halt;
    s_sleep_halt |=> !driver_run && !pump_run;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("driver running in deep sleep");

  property p_run_free;
    !(st_reg.ctrl.halt_in_wait && st_reg.wait_sync)
      && !(st_reg.ctrl.halt_in_deep_sleep && st_reg.sleep_sync) |=> driver_run;
  endproperty
  a_run_free: assert property (p_run_free)
    else $error("driver halted without cause");

  property p_frame_spacing;
    frame_start |=> (!frame_start) [*8];
  endproperty
  a_frame_spacing: assert property (p_frame_spacing)
    else $error("frames closer than the panel divider");

  property p_regulator;
    regulator_on |-> pump_run && $past(st_reg.supply.charge_pump_enable);
  endproperty
  a_regulator: assert property (p_regulator)
    else $error("regulator on without pump");

  property p_frame_pulse;
    frame_start |-> s_frame_pulse;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse)
    else $error("frame start wider than one cycle");

  property p_irq_out;
    irq == (st_reg.irq_stat && st_reg.irq_mask);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output disagrees with flag and mask");

  property p_pump_needs_driver;
    pump_run |-> driver_run;
  endproperty
  a_pump_needs_driver: assert property (p_pump_needs_driver)
    else $error("pump running with driver halted");

  property p_flag_sticky;
    st_reg.irq_stat && !(st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
      |=> st_reg.irq_stat;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("frame flag lost without a write");

  property p_halt_restart;
    !driver_run |=> bp_index == '0;
  endproperty
  a_halt_restart: assert property (p_halt_restart)
    else $error("sequence not cleared while halted");

  property p_onehot_run;
    driver_run && $past(driver_run) |-> $onehot(backplane_drive);
  endproperty
  a_onehot_run: assert property (p_onehot_run)
    else $error("no backplane driven while running");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before bready");

  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped before rready");
endmodule : lcdc_top
`default_nettype wire

// ==== logic/lcdc_regs.svh ====
// Purpose: register map, reset values and timing counts of the LCD control slice
// Assumes: AXI4-Lite slave, 32-bit data, aclk at 250 MHz
// Notes: Included by the lcdc_top and lcdc_frame_gen modules; definitions only
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH
`define LCDC_AW 8
`define LCDC_OFS_CTRL 8'h00
`define LCDC_OFS_SETUP 8'h04
`define LCDC_OFS_SUPPLY 8'h08
`define LCDC_OFS_STAT 8'h0C
`define LCDC_OFS_MASK 8'h10
`define LCDC_OFS_STATE 8'h14
`define LCDC_SETUP_RST 8'h03
`define LCDC_DUTY_RST 3'h3
`define LCDC_SUPPLY_EXT 2'h3
`define LCDC_RESP_OKAY 2'h0
`define LCDC_RESP_SLVERR 2'h2
`define LCDC_ACLK_HZ 250000000
`define LCDC_PANEL_HZ 32768
`define LCDC_PANEL_DIV (`LCDC_ACLK_HZ / `LCDC_PANEL_HZ)
`define LCDC_DIV_W 13
`endif

// ==== logic/lcdc_pkg.sv ====
// Purpose: types shared by the LCD control slice
// Assumes: lcdc_regs.svh for the numbers
// Notes: Struct layouts give the register field positions
package lcdc_pkg;
  typedef struct packed {
    logic frame_irq_enable;
    logic [3:0] rsvd;
    logic complementary_drive_enable;
    logic halt_in_wait;
    logic halt_in_deep_sleep;
  } lcdc_ctrl_t;
  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] frame_prescaler;
    logic [2:0] duty_sel;
  } lcdc_setup_t;
  typedef struct packed {
    logic [3:0] rsvd;
    logic charge_pump_enable;
    logic regulator_enable;
    logic [1:0] supply_source_sel;
  } lcdc_supply_t;
  typedef enum {
    REG_CTRL, REG_SETUP, REG_SUPPLY, REG_STAT, REG_MASK, REG_STATE, REG_NONE
  } lcdc_reg_t;
  typedef struct packed {
    logic [7:0] backplane_drive;
    logic driver_run;
    logic pump_run;
    logic regulator_on;
    logic gpio_complementary;
    logic gpio_ref_rail3;
  } lcdc_pins_t;
  typedef struct packed {
    logic [12:0] panel_cnt;
    logic [2:0] step_cnt;
    logic [2:0] bp_index;
    logic frame_start;
  } lcdc_fg_t;
  typedef struct packed {
    lcdc_ctrl_t ctrl;
    lcdc_setup_t setup;
    lcdc_supply_t supply;
    logic irq_stat;
    logic irq_mask;
    logic wait_meta;
    logic wait_sync;
    logic sleep_meta;
    logic sleep_sync;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    lcdc_pins_t pins;
    logic irq;
  } lcdc_st_t;
endpackage : lcdc_pkg

// ==== logic/lcdc_frame_gen.sv ====
// Purpose: backplane sequencer and frame start pulse
// Assumes: run comes from a flop on aclk
// Notes: Halting clears the sequence so a restart begins a fresh frame
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_regs.svh"
module lcdc_frame_gen
  import lcdc_pkg::*;
#(
  parameter int unsigned PANEL_DIV = `LCDC_PANEL_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] duty_sel,
  input wire logic [2:0] frame_prescaler,
  output logic [2:0] bp_index,
  output logic frame_start
);
  localparam logic [12:0] DIV_LAST = 13'(PANEL_DIV - 1);
  lcdc_fg_t st_reg;
  lcdc_fg_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.frame_start = 1'b0;
    if (!run) begin
      st_next.panel_cnt = '0;
      st_next.step_cnt = '0;
      st_next.bp_index = '0;
    end else if (st_reg.bp_index > duty_sel) begin
      // A lowered duty must never leave a backplane beyond the new range
      st_next.panel_cnt = '0;
      st_next.step_cnt = '0;
      st_next.bp_index = '0;
    end else if (st_reg.panel_cnt != DIV_LAST) begin
      st_next.panel_cnt = st_reg.panel_cnt + 13'h0001;
    end else begin
      st_next.panel_cnt = '0;
      // Each backplane lasts prescaler+1 panel clocks
      if (st_reg.step_cnt != frame_prescaler) begin
        st_next.step_cnt = st_reg.step_cnt + 3'h1;
      end else begin
        st_next.step_cnt = '0;
        if (st_reg.bp_index >= duty_sel) begin
          st_next.bp_index = '0;
          st_next.frame_start = 1'b1;
        end else begin
          st_next.bp_index = st_reg.bp_index + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bp_index = st_reg.bp_index;
  assign frame_start = st_reg.frame_start;
endmodule : lcdc_frame_gen
`default_nettype wire

// ==== tb/lcdc_glass_model.sv ====
// Purpose: LCD glass seen from its backplane electrodes
// Assumes: one-hot backplane drive, all zero while halted
// Notes: Reports last frame length, last slot length and time since last change
`timescale 1ns/1ps
`default_nettype none
module lcdc_glass_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] backplane_drive,
  output int frame_len,
  output int slot_len,
  output int stable_len,
  output logic bad
);
  logic [7:0] prev_reg;
  int seen;
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 8'h00;
      seen <= 0;
      frame_len <= 0;
      slot_len <= 0;
      stable_len <= 0;
      bad <= 1'b0;
    end else begin
      prev_reg <= backplane_drive;
      // Two electrodes driven at once would damage the glass image
      if ((backplane_drive & (backplane_drive - 8'h01)) != 8'h00) bad <= 1'b1;
      if (backplane_drive != prev_reg) begin
        slot_len <= stable_len + 1;
        stable_len <= 0;
        if (backplane_drive == 8'h01) begin
          frame_len <= seen;
          seen <= 1;
        end else begin
          seen <= seen + 1;
        end
      end else begin
        stable_len <= stable_len + 1;
      end
    end
  end
endmodule : lcdc_glass_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the LCD control slice
// Assumes: PANEL_DIV shortened to 10 so frames stay short
// Notes: Register map offsets as in the register header
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lcdc_pkg::*;
  localparam int unsigned PDIV = 10;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] setup;
    logic [7:0] supply;
    logic comp;
    logic pump;
    logic regu;
  } lcdc_row_t;
  lcdc_row_t rows [8] = '{
    '{8'h04, 8'h00, 8'h03, 1'b1, 1'b0, 1'b0}, '{8'h04, 8'h09, 8'h07, 1'b0, 1'b0, 1'b0},
    '{8'h04, 8'h12, 8'h02, 1'b0, 1'b0, 1'b0}, '{8'h00, 8'h03, 8'h03, 1'b0, 1'b0, 1'b0},
    '{8'h04, 8'h04, 8'h0B, 1'b1, 1'b1, 1'b0}, '{8'h04, 8'h0D, 8'h0F, 1'b0, 1'b1, 1'b1},
    '{8'h06, 8'h06, 8'h0C, 1'b0, 1'b1, 1'b1}, '{8'h01, 8'h07, 8'h08, 1'b0, 1'b1, 1'b0}};
  logic [7:0] rst_exp [5] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  logic [3:0] lp [5] = '{4'b1010, 4'b1001, 4'b0101, 4'b0110, 4'b1111};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic wait_mode, deep_sleep_mode, driver_run, pump_run, regulator_on;
  logic gpio_complementary, gpio_ref_rail3, irq, bad, on;
  logic [7:0] backplane_drive;
  logic [31:0] rd;
  int errors = 0, comparisons = 0, frame_len, slot_len, stable_len, slot, n;

  lcdc_top #(.PANEL_DIV(PDIV)) lcdc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_mode, .deep_sleep_mode, .backplane_drive,
    .driver_run, .pump_run, .regulator_on, .gpio_complementary, .gpio_ref_rail3, .irq);
  lcdc_glass_model lcdc_glass_model_i (.aclk, .aresetn, .backplane_drive, .frame_len,
    .slot_len, .stable_len, .bad);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Bus tasks start after an edge so no strobe is assigned twice in one step
  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h000000, data};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 50) errors++;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 50) errors++;
  endtask : axi_read

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {wait_mode, deep_sleep_mode} = 2'h0;
    do_reset();
    chk_bit(irq, 1'b0);
    for (int i = 0; i < 5; i++) begin
      axi_read(8'(i * 4), rd, rsp);
      chk_word(rd, {24'h000000, rst_exp[i]});
    end
    axi_read(8'h18, rd, rsp);
    chk_word({rd[29:0], rsp}, 32'h00000002);
    axi_write(8'h18, 8'hFF, rsp);
    chk_word({30'h0, rsp}, 32'h00000002);
    foreach (rows[i]) begin
      axi_write(8'h00, rows[i].ctrl, rsp);
      axi_write(8'h04, rows[i].setup, rsp);
      axi_write(8'h08, rows[i].supply, rsp);
      repeat (400) @(posedge aclk);
      chk_bit(gpio_complementary, rows[i].comp);
      chk_bit(gpio_ref_rail3, rows[i].comp);
      chk_bit(pump_run, rows[i].pump);
      chk_bit(regulator_on, rows[i].regu);
      slot = (int'(rows[i].setup[5:3]) + 1) * PDIV;
      if (rows[i].setup[2:0] == 3'h0) begin
        chk_word(backplane_drive, 32'h00000001);
        chk_bit(stable_len > 3 * slot, 1'b1);
        axi_read(8'h14, rd, rsp);
        chk_word(rd, 32'h00000013);
      end else begin
        chk_word(32'(frame_len), 32'(rows[i].setup[2:0]) + 32'd1);
        chk_word(32'(slot_len), 32'(slot));
      end
      axi_read(8'h04, rd, rsp);
      chk_word(rd, {24'h000000, rows[i].setup});
    end
    chk_bit(bad, 1'b0);
    // Frame interrupt at duty 1/4: 40 cycles a frame
    axi_write(8'h04, 8'h03, rsp);
    axi_write(8'h0C, 8'h01, rsp);
    axi_write(8'h10, 8'h01, rsp);
    axi_write(8'h00, 8'h80, rsp);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk_bit(irq, 1'b1);
    chk_bit(n < 45, 1'b1);
    axi_write(8'h00, 8'h00, rsp);
    axi_write(8'h0C, 8'h01, rsp);
    repeat (200) @(posedge aclk);
    chk_bit(irq, 1'b0);
    axi_read(8'h0C, rd, rsp);
    chk_word(rd, 32'h00000000);
    axi_write(8'h10, 8'h00, rsp);
    axi_write(8'h00, 8'h80, rsp);
    repeat (100) @(posedge aclk);
    axi_read(8'h0C, rd, rsp);
    chk_word(rd, 32'h00000001);
    chk_bit(irq, 1'b0);
    // Low-power cases: {halt_in_wait, halt_in_deep_sleep, wait, deep sleep}
    axi_write(8'h08, 8'h08, rsp);
    foreach (lp[i]) begin
      axi_write(8'h00, {6'h00, lp[i][3:2]}, rsp);
      wait_mode <= lp[i][1];
      deep_sleep_mode <= lp[i][0];
      on = !((lp[i][3] & lp[i][1]) | (lp[i][2] & lp[i][0]));
      repeat (8) @(posedge aclk);
      chk_bit(driver_run, on);
      chk_bit(pump_run, on);
      if (!on) chk_word(backplane_drive, 32'h00000000);
    end
    wait_mode <= 1'b0;
    deep_sleep_mode <= 1'b0;
    axi_write(8'h04, 8'h07, rsp);
    do_reset();
    axi_read(8'h04, rd, rsp);
    chk_word(rd, 32'h00000003);
    wrap_up();
  end

  // Whole run is about 3800 cycles
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
